// File: pkg/adcc_pkg.sv
package adcc_pkg;

  // clocking
  localparam int CLK_HZ       = 40_000_000;
  localparam int MCLK_HZ      = 1_000_000;
  localparam int MCLK_DIV     = CLK_HZ / MCLK_HZ;
  localparam int MOD_DIV      = 4;
  localparam int MOD_HZ       = MCLK_HZ / MOD_DIV;
  localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int RDY_PULSE_NS = 8000;
  localparam int RDY_PULSE_CYC = RDY_PULSE_NS / CLK_NS;

  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_RESULT  = 6'h00;
  localparam logic [5:0] IDX_CTRL1   = 6'h01;
  localparam logic [5:0] IDX_DEVCTRL = 6'h09;
  localparam logic [5:0] IDX_CTRL2   = 6'h10;
  localparam logic [5:0] IDX_SYNTH   = 6'h14;
  localparam logic [5:0] IDX_STATUS  = 6'h15;

  // field positions
  localparam int CONV_MODE_BIT = 15;
  localparam int MEAS_HI       = 13;
  localparam int MEAS_LO       = 11;
  localparam int PD_BIT        = 7;
  localparam int RATE_HI       = 6;
  localparam int RATE_LO       = 4;
  localparam int DEVINIT_HI    = 14;
  localparam int DEVINIT_LO    = 13;
  localparam int REF_HI        = 6;
  localparam int REF_LO        = 5;
  localparam int PSEL_HI       = 4;
  localparam int PSEL_LO       = 0;
  localparam int SYNTH_HI      = 9;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_RDY_BIT    = 1;

  // reset values
  localparam logic       CONV_MODE_RST = 1'h0;
  localparam logic [2:0] MEAS_RST      = 3'h0;
  localparam logic       PD_RST        = 1'h1;
  localparam logic [2:0] RATE_RST      = 3'h4;
  localparam logic [1:0] DEVINIT_RST   = 2'h0;
  localparam logic [1:0] REF_RST       = 2'h0;
  localparam logic [4:0] PSEL_RST      = 5'h00;
  localparam logic [9:0] SYNTH_RST     = 10'h00A;

  // output codes
  localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FS = 16'h8000;
  localparam logic [15:0] CODE_ZERO   = 16'h0000;

  typedef enum logic [2:0] {
    ADCC_OFF    = 3'b001,
    ADCC_CONT   = 3'b010,
    ADCC_SINGLE = 3'b100
  } adcc_state_t;

  localparam longint GAIN_NUM = 64'h0000_0000_8000_0000;

  // {decimation ratio, gain = 2^31 / ratio}
  function automatic logic [38:0] rate_entry(input int sps);
    return {15'(MOD_HZ / sps), 24'(GAIN_NUM / longint'(MOD_HZ / sps))};
  endfunction

  function automatic logic [38:0] rate_lookup(input logic [2:0] code);
    case (code)
      3'h0:    rate_lookup = rate_entry(8);
      3'h1:    rate_lookup = rate_entry(16);
      3'h2:    rate_lookup = rate_entry(32);
      3'h3:    rate_lookup = rate_entry(64);
      3'h4:    rate_lookup = rate_entry(128);
      3'h5:    rate_lookup = rate_entry(250);
      3'h6:    rate_lookup = rate_entry(475);
      default: rate_lookup = rate_entry(860);
    endcase
  endfunction

endpackage

// File: verilog/adcc_sinc1.sv
`timescale 1ns/1ps
module adcc_sinc1 #(
  parameter int RATIO_W = 15,
  parameter int GAIN_W  = 24
) (
  input  wire logic               clk_i,          // system clock
  input  wire logic               rst_i,          // sync reset
  input  wire logic               run_i,          // conversion enabled
  input  wire logic               mod_en_i,       // modulator sample strobe
  input  wire logic               mod_bit_i,      // modulator bit
  input  wire logic [RATIO_W-1:0] ratio_i,        // decimation ratio
  input  wire logic [GAIN_W-1:0]  gain_i,         // scale factor
  input  wire logic               single_ended_i, // clamp negatives
  output logic                    done_o,         // result strobe
  output logic [15:0]             code_o          // result code
);

  localparam int ACC_W  = RATIO_W + 2;
  localparam int PROD_W = ACC_W + GAIN_W + 1;
  localparam int SC_W   = PROD_W - 16;
  localparam logic signed [ACC_W-1:0] STEP_UP = ACC_W'(1);
  localparam logic signed [ACC_W-1:0] STEP_DN = -STEP_UP;

  if (RATIO_W < 2 || RATIO_W > 16 || GAIN_W < 8) begin : g_chk
    $error("adcc_sinc1: unsupported width");
  end

  logic [RATIO_W-1:0]       cnt_ff;
  logic [RATIO_W-1:0]       ratio_ff;
  logic [GAIN_W-1:0]        gain_ff;
  logic signed [ACC_W-1:0]  acc_ff;
  logic signed [ACC_W-1:0]  nxt_acc;
  logic signed [PROD_W-1:0] prod;
  logic [SC_W-1:0]          scaled;
  logic                     last;
  logic                     ovf;
  logic [15:0]              nxt_code;

  assign nxt_acc = acc_ff + (mod_bit_i ? STEP_UP : STEP_DN);
  assign last    = mod_en_i && (cnt_ff == ratio_ff - RATIO_W'(1));
  assign prod    = PROD_W'(nxt_acc) * $signed({1'b0, gain_ff});
  assign scaled  = prod[PROD_W-1:16];
  assign ovf     = !(&scaled[SC_W-1:15]) && (|scaled[SC_W-1:15]);

  always_comb
  begin
    if (ovf)
      nxt_code = scaled[SC_W-1] ? adcc_pkg::CODE_NEG_FS
                                : adcc_pkg::CODE_POS_FS;
    else
      nxt_code = scaled[15:0];
    if (single_ended_i && nxt_code[15])
      nxt_code = adcc_pkg::CODE_ZERO;
  end

  // first-order sinc: one up/down count per modulator sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || last)
    begin
      cnt_ff   <= '0;
      acc_ff   <= '0;
      ratio_ff <= ratio_i;
      gain_ff  <= gain_i;
    end
    else if (mod_en_i)
    begin
      cnt_ff <= cnt_ff + RATIO_W'(1);
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      code_o <= adcc_pkg::CODE_ZERO;
    end
    else
    begin
      done_o <= run_i && last;
      if (run_i && last)
        code_o <= nxt_code;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_decim_count: assert property (run_i && last |=> done_o && cnt_ff == 0)
    else $error("conversion did not end after ratio samples");
  a_single_ended_code: assert property (done_o && single_ended_i |-> !code_o[15])
    else $error("negative code in single-ended measurement");

endmodule

// File: verilog/adcc_lo_gen.sv
`timescale 1ns/1ps
module adcc_lo_gen #(
  parameter int DIV_W = 10
) (
  input  wire logic             clk_i,        // system clock
  input  wire logic             rst_i,        // sync reset
  input  wire logic             tick_i,       // synthesizer clock strobe
  input  wire logic [DIV_W-1:0] div_i,        // ticks per quarter period
  output logic                  lo_i_o,       // in-phase switch drive
  output logic                  lo_q_o,       // quadrature switch drive
  output logic                  synth_step_o  // synthesizer phase step
);

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("adcc_lo_gen: unsupported divider width");
  end

  logic [DIV_W-1:0] cnt_ff;
  logic [1:0]       quad_ff;
  logic             wrap;
  logic [1:0]       nxt_quad;

  // zero divider acts as one
  assign wrap     = tick_i && (cnt_ff + DIV_W'(1) >= div_i);
  assign nxt_quad = quad_ff + 2'h1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff       <= '0;
      quad_ff      <= 2'h0;
      lo_i_o       <= 1'b1;
      lo_q_o       <= 1'b0;
      synth_step_o <= 1'b0;
    end
    else
    begin
      synth_step_o <= wrap;
      if (wrap)
      begin
        cnt_ff  <= '0;
        quad_ff <= nxt_quad;
        lo_i_o  <= !nxt_quad[1];
        lo_q_o  <= nxt_quad[1] ^ nxt_quad[0];
      end
      else if (tick_i)
        cnt_ff <= cnt_ff + DIV_W'(1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lo_same_clock: assert property ($changed(lo_i_o) |-> synth_step_o)
    else $error("in-phase drive moved off a synthesizer step");
  a_lo_quarter_lag: assert property ($rose(lo_q_o) |-> lo_i_o && $past(lo_i_o))
    else $error("quadrature drive not a quarter period behind");

endmodule

// File: verilog/adcc_core.sv
// Functional notes
// - modulator runs at master clock divided by four, 250 kHz.
// - first-order sinc decimation, programmable ratio, 8 to 860 samples/s.
// - 16-bit two's complement result, saturating at 7FFFh and 8000h.
// - single-ended measurement yields only non-negative codes.
// - input source select plus differential or single-ended choice.
// - reference select between regulator and internal reference.
// - continuous mode stores each result and restarts at once.
// - single-shot waits for trigger write of one, then bit reads zero.
// - single-shot end sets trigger bit again and powers converter down.
// - trigger write during a running single-shot is ignored.
// - reset loads every register bit with its default.
// - converter stays powered down after reset until trigger bit written.
// - demodulator drive derived from the synthesizer clock, same phase.
// - quadrature drive lags in-phase drive by a quarter period.
// - conversion mode bit, default continuous.
// - three-bit data-rate field, default 100b.
// - ready low at single-shot end; about 8 us pulse in continuous.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module adcc_core #(
  parameter int ADR_W = 8
) (
  input  wire logic             clk_i,          // 40 MHz system clock
  input  wire logic             rst_i,          // sync reset, active high
  input  wire logic             wb_cyc_i,       // wishbone cycle
  input  wire logic             wb_stb_i,       // wishbone strobe
  input  wire logic             wb_we_i,        // wishbone write enable
  input  wire logic [ADR_W-1:0] wb_adr_i,       // wishbone byte address
  input  wire logic [3:0]       wb_sel_i,       // wishbone byte lanes
  input  wire logic [31:0]      wb_dat_i,       // wishbone write data
  output logic      [31:0]      wb_dat_o,       // wishbone read data
  output logic                  wb_ack_o,       // wishbone acknowledge
  input  wire logic             mod_bit_i,      // modulator bitstream pin
  output logic                  mod_clk_o,      // modulator clock
  output logic                  adc_pwr_o,      // converter powered
  output logic                  single_ended_o, // measure against ground
  output logic      [4:0]       periph_sel_o,   // first-level input select
  output logic      [1:0]       ref_sel_o,      // reference select
  output logic      [1:0]       dev_init_o,     // device init bits
  output logic                  rdy_n_o,        // conversion ready, low
  output logic                  lo_i_o,         // in-phase demod drive
  output logic                  lo_q_o,         // quadrature demod drive
  output logic                  synth_step_o    // synthesizer phase step
);

  if (ADR_W < 8 || ADR_W > 32) begin : g_chk
    $error("adcc_core: address width must be 8 to 32");
  end

  localparam logic [5:0] MCLK_LAST = 6'(adcc_pkg::MCLK_DIV - 1);
  localparam logic [1:0] MOD_LAST  = 2'(adcc_pkg::MOD_DIV - 1);
  localparam logic [8:0] RDY_CNT   = 9'(adcc_pkg::RDY_PULSE_CYC);
  localparam logic [7:0] MOD_GAP   =
    8'(adcc_pkg::MCLK_DIV * adcc_pkg::MOD_DIV - 1);

  adcc_pkg::adcc_state_t state_ff;

  logic [5:0]  mclk_cnt_ff;
  logic        mclk_tick_ff;
  logic [1:0]  mod_cnt_ff;
  logic        mod_tick_ff;
  logic        sync1_ff;
  logic        sync2_ff;
  logic        ack_ff;
  logic [31:0] rd_ff;
  logic        conv_mode_ff;
  logic [2:0]  meas_ff;
  logic        pd_ff;
  logic [2:0]  rate_ff;
  logic [1:0]  devinit_ff;
  logic [1:0]  ref_ff;
  logic [4:0]  psel_ff;
  logic [9:0]  synth_div_ff;
  logic [15:0] result_ff;
  logic        rdy_n_ff;
  logic [8:0]  rdy_cnt_ff;
  logic        pwr_ff;
  logic        se_ff;
  logic        mod_clk_ff;
  logic [5:0]  idx;
  logic        req;
  logic        wr_lo;
  logic        wr_hi;
  logic        pd_wr;
  logic        trig;
  logic        run;
  logic        done;
  logic [15:0] code;
  logic [38:0] rate_row;
  logic [31:0] nxt_rd;

  // master clock and modulator clock strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mclk_cnt_ff  <= 6'h00;
      mclk_tick_ff <= 1'b0;
    end
    else
    begin
      mclk_tick_ff <= (mclk_cnt_ff == MCLK_LAST);
      mclk_cnt_ff  <= (mclk_cnt_ff == MCLK_LAST) ? 6'h00
                                                 : mclk_cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mod_cnt_ff  <= 2'h0;
      mod_tick_ff <= 1'b0;
      mod_clk_ff  <= 1'b0;
    end
    else
    begin
      mod_tick_ff <= mclk_tick_ff && (mod_cnt_ff == MOD_LAST);
      if (mclk_tick_ff)
      begin
        mod_cnt_ff <= mod_cnt_ff + 2'h1;
        mod_clk_ff <= !mod_cnt_ff[1];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= mod_bit_i;
      sync2_ff <= sync1_ff;
    end
  end

  // register bus decode
  assign req   = wb_cyc_i && wb_stb_i && !ack_ff;
  assign idx   = wb_adr_i[7:2];
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];
  assign pd_wr = wr_lo && (idx == adcc_pkg::IDX_CTRL1);
  assign trig  = pd_wr && wb_dat_i[adcc_pkg::PD_BIT];
  assign run   = (state_ff != adcc_pkg::ADCC_OFF);

  always_comb
  begin
    nxt_rd = 32'h0000_0000;
    if (idx == adcc_pkg::IDX_RESULT)
      nxt_rd = {16'h0000, result_ff};
    else if (idx == adcc_pkg::IDX_CTRL1)
      nxt_rd = {16'h0000, conv_mode_ff, 1'b0, meas_ff, 3'h0, pd_ff,
                rate_ff, 4'h0};
    else if (idx == adcc_pkg::IDX_DEVCTRL)
      nxt_rd = {16'h0000, 1'b0, devinit_ff, 13'h0000};
    else if (idx == adcc_pkg::IDX_CTRL2)
      nxt_rd = {16'h0000, 9'h000, ref_ff, psel_ff};
    else if (idx == adcc_pkg::IDX_SYNTH)
      nxt_rd = {16'h0000, 6'h00, synth_div_ff};
    else if (idx == adcc_pkg::IDX_STATUS)
      nxt_rd = {16'h0000, 14'h0000, !rdy_n_ff, run};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rd_ff  <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req;
      if (req && !wb_we_i)
        rd_ff <= nxt_rd;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_mode_ff <= adcc_pkg::CONV_MODE_RST;
      meas_ff      <= adcc_pkg::MEAS_RST;
      rate_ff      <= adcc_pkg::RATE_RST;
      devinit_ff   <= adcc_pkg::DEVINIT_RST;
      ref_ff       <= adcc_pkg::REF_RST;
      psel_ff      <= adcc_pkg::PSEL_RST;
      synth_div_ff <= adcc_pkg::SYNTH_RST;
    end
    else
    begin
      if (wr_hi && idx == adcc_pkg::IDX_CTRL1)
      begin
        conv_mode_ff <= wb_dat_i[adcc_pkg::CONV_MODE_BIT];
        meas_ff <= wb_dat_i[adcc_pkg::MEAS_HI:adcc_pkg::MEAS_LO];
      end
      if (wr_lo && idx == adcc_pkg::IDX_CTRL1)
        rate_ff <= wb_dat_i[adcc_pkg::RATE_HI:adcc_pkg::RATE_LO];
      if (wr_hi && idx == adcc_pkg::IDX_DEVCTRL)
        devinit_ff <=
          wb_dat_i[adcc_pkg::DEVINIT_HI:adcc_pkg::DEVINIT_LO];
      if (wr_lo && idx == adcc_pkg::IDX_CTRL2)
      begin
        ref_ff  <= wb_dat_i[adcc_pkg::REF_HI:adcc_pkg::REF_LO];
        psel_ff <= wb_dat_i[adcc_pkg::PSEL_HI:adcc_pkg::PSEL_LO];
      end
      if (wr_lo && idx == adcc_pkg::IDX_SYNTH)
        synth_div_ff[7:0] <= wb_dat_i[7:0];
      if (wr_hi && idx == adcc_pkg::IDX_SYNTH)
        synth_div_ff[adcc_pkg::SYNTH_HI:8] <=
          wb_dat_i[adcc_pkg::SYNTH_HI:8];
    end
  end

  // conversion sequencing and trigger/power-down bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= adcc_pkg::ADCC_OFF;
      pd_ff    <= adcc_pkg::PD_RST;
    end
    else
    begin
      case (state_ff)
        adcc_pkg::ADCC_OFF:
        begin
          if (conv_mode_ff && trig)
          begin
            state_ff <= adcc_pkg::ADCC_SINGLE;
            pd_ff    <= 1'b0;
          end
          else
          begin
            if (pd_wr)
              pd_ff <= wb_dat_i[adcc_pkg::PD_BIT];
            if (!conv_mode_ff && !pd_ff)
              state_ff <= adcc_pkg::ADCC_CONT;
          end
        end
        adcc_pkg::ADCC_CONT:
        begin
          if (pd_wr)
            pd_ff <= wb_dat_i[adcc_pkg::PD_BIT];
          if (pd_ff || conv_mode_ff)
            state_ff <= adcc_pkg::ADCC_OFF;
        end
        adcc_pkg::ADCC_SINGLE:
        begin
          // bus writes to the bit are dropped here
          if (done)
          begin
            pd_ff    <= 1'b1;
            state_ff <= adcc_pkg::ADCC_OFF;
          end
        end
        default:
        begin
          state_ff <= adcc_pkg::ADCC_OFF;
          pd_ff    <= adcc_pkg::PD_RST;
        end
      endcase
    end
  end

  assign rate_row = adcc_pkg::rate_lookup(rate_ff);

  adcc_sinc1 #(
    .RATIO_W        (15),
    .GAIN_W         (24)
  ) u_sinc (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_i          (run),
    .mod_en_i       (mod_tick_ff),
    .mod_bit_i      (sync2_ff),
    .ratio_i        (rate_row[38:24]),
    .gain_i         (rate_row[23:0]),
    .single_ended_i (se_ff),
    .done_o         (done),
    .code_o         (code)
  );

  adcc_lo_gen #(
    .DIV_W          (10)
  ) u_lo (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .tick_i         (mclk_tick_ff),
    .div_i          (synth_div_ff),
    .lo_i_o         (lo_i_o),
    .lo_q_o         (lo_q_o),
    .synth_step_o   (synth_step_o)
  );

  // result holding and ready signalling
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_ff <= adcc_pkg::CODE_ZERO;
    else if (done)
      result_ff <= code;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdy_n_ff   <= 1'b1;
      rdy_cnt_ff <= 9'h000;
    end
    else if (done && state_ff == adcc_pkg::ADCC_SINGLE)
    begin
      rdy_n_ff   <= 1'b0;
      rdy_cnt_ff <= 9'h000;
    end
    else if (done)
    begin
      rdy_n_ff   <= 1'b0;
      rdy_cnt_ff <= RDY_CNT;
    end
    else if (rdy_cnt_ff != 9'h000)
    begin
      rdy_cnt_ff <= rdy_cnt_ff - 9'h001;
      if (rdy_cnt_ff == 9'h001)
        rdy_n_ff <= 1'b1;
    end
    else if (state_ff == adcc_pkg::ADCC_OFF && conv_mode_ff && trig)
      rdy_n_ff <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_ff <= 1'b0;
      se_ff  <= 1'b0;
    end
    else
    begin
      pwr_ff <= run;
      se_ff  <= (meas_ff != adcc_pkg::MEAS_RST);
    end
  end

  assign wb_ack_o       = ack_ff;
  assign wb_dat_o       = rd_ff;
  assign mod_clk_o      = mod_clk_ff;
  assign adc_pwr_o      = pwr_ff;
  assign single_ended_o = se_ff;
  assign periph_sel_o   = psel_ff;
  assign ref_sel_o      = ref_ff;
  assign dev_init_o     = devinit_ff;
  assign rdy_n_o        = rdy_n_ff;

  // helper: cycles since last modulator strobe
  logic [7:0] gap_ff;
  logic       seen_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_ff  <= 8'h00;
      seen_ff <= 1'b0;
    end
    else if (mod_tick_ff)
    begin
      gap_ff  <= 8'h00;
      seen_ff <= 1'b1;
    end
    else if (gap_ff != 8'hFF)
      gap_ff <= gap_ff + 8'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mod_tick_rate: assert property (mod_tick_ff && seen_ff |-> gap_ff == MOD_GAP)
    else $error("modulator strobe spacing wrong");
  a_cont_restart: assert property (state_ff == adcc_pkg::ADCC_CONT && done && !pd_ff && !conv_mode_ff |=> state_ff == adcc_pkg::ADCC_CONT && result_ff == $past(code))
    else $error("continuous mode did not store and continue");
  a_single_start: assert property (state_ff == adcc_pkg::ADCC_OFF && conv_mode_ff && trig |=> !pd_ff && state_ff == adcc_pkg::ADCC_SINGLE ##1 adc_pwr_o)
    else $error("single-shot trigger not taken");
  a_single_finish: assert property (state_ff == adcc_pkg::ADCC_SINGLE && done |=> pd_ff && !run ##1 !adc_pwr_o)
    else $error("single-shot end did not restore bit and power down");
  a_busy_write_ignored: assert property (state_ff == adcc_pkg::ADCC_SINGLE && !done |=> !pd_ff && state_ff == adcc_pkg::ADCC_SINGLE)
    else $error("single-shot disturbed while running");
  a_reset_defaults: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> pd_ff && rate_ff == adcc_pkg::RATE_RST && !conv_mode_ff && psel_ff == adcc_pkg::PSEL_RST && !adc_pwr_o)
    else $error("register default missing after reset");
  a_idle_powered_down: assert property (state_ff == adcc_pkg::ADCC_OFF && !trig && !(pd_wr && !wb_dat_i[adcc_pkg::PD_BIT]) && pd_ff |=> !run)
    else $error("conversion started without trigger bit write");
  a_result_hold: assert property (!done |=> $stable(result_ff))
    else $error("result changed without a finished conversion");
  a_rdy_pulse_len: assert property (done && state_ff == adcc_pkg::ADCC_CONT && !pd_ff && !conv_mode_ff |=> !rdy_n_o && rdy_cnt_ff == RDY_CNT)
    else $error("continuous ready pulse not started");

endmodule

// File: test/adcc_mod_model.sv
`timescale 1ns/1ps
// bitstream source: steady level sampled on each modulator clock
module adcc_mod_model (
  input  wire logic mod_clk_i, // modulator clock
  input  wire logic ones_i,    // wanted bit level
  output logic      bit_o      // modulator bitstream
);
  initial bit_o = 1'b0;
  always @(posedge mod_clk_i) bit_o <= ones_i;
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, mod_clk_o, mod_bit, ones = 0;
  logic        adc_pwr_o, single_ended_o, rdy_n_o;
  logic [1:0]  ref_sel_o;
  logic [4:0]  periph_sel_o;
  logic        lo_i_o, lo_q_o, synth_step_o;
  int          n_low;
  logic [1:0]  dev_init_o;
  int          n_errors = 0;
  int          checked = 0;
  adcc_core adcc_core_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_bit_i(mod_bit),
    .mod_clk_o(mod_clk_o), .adc_pwr_o(adc_pwr_o),
    .single_ended_o(single_ended_o), .periph_sel_o(periph_sel_o),
    .ref_sel_o(ref_sel_o), .dev_init_o(dev_init_o), .rdy_n_o(rdy_n_o),
    .lo_i_o(lo_i_o), .lo_q_o(lo_q_o), .synth_step_o(synth_step_o)
  );
  adcc_mod_model adcc_mod_model_inst (
    .mod_clk_i(mod_clk_o), .ones_i(ones), .bit_o(mod_bit)
  );
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000);
    chk("read", e, q);
  endtask
  task automatic wait_rdy(input logic v);
    while (rdy_n_o !== v) @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #2400us;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h04, 32'h0000_00C0);
    rd(8'h24, 32'h0);
    wb(1'b1, 8'h24, 16'h6000);
    rd(8'h24, 32'h0000_6000);
    chk("dev_init", 32'(dev_init_o), 32'h3);
    rd(8'hFC, 32'h0);
    rd(8'h50, 32'h0000_000A);
    chk("pwr idle", 32'(adc_pwr_o), 32'h0);
    $display("test defaults done");
    wb(1'b1, 8'h04, 16'h0870);
    @(posedge clk_i);
    chk("single ended", 32'(single_ended_o), 32'h1);
    wait_rdy(1'b0);
    n_low = 0;
    while (rdy_n_o !== 1'b1)
    begin
      @(posedge clk_i);
      n_low++;
    end
    chk("rdy pulse", n_low, adcc_pkg::RDY_PULSE_CYC);
    rd(8'h00, 32'h0);
    $display("test continuous clamp done");
    ones = 1'b1;
    wb(1'b1, 8'h04, 16'h80F0);
    // let the bitstream settle high before the trigger
    repeat (170) @(posedge clk_i);
    wb(1'b1, 8'h04, 16'h80F0);
    rd(8'h04, 32'h0000_8070);
    rd(8'h54, 32'h0000_0001);
    chk("pwr on", 32'(adc_pwr_o), 32'h1);
    wb(1'b1, 8'h04, 16'h80F0);
    rd(8'h04, 32'h0000_8070);
    wb(1'b1, 8'h40, 16'h0045);
    chk("ref sel", 32'(ref_sel_o), 32'h2);
    chk("input sel", 32'(periph_sel_o), 32'h5);
    while (lo_q_o !== 1'b0) @(posedge clk_i);
    while (lo_q_o !== 1'b1) @(posedge clk_i);
    chk("lo i at q rise", 32'(lo_i_o), 32'h1);
    chk("step at q rise", 32'(synth_step_o), 32'h1);
    while (lo_i_o !== 1'b0) @(posedge clk_i);
    chk("lo q at i fall", 32'(lo_q_o), 32'h1);
    chk("step at i fall", 32'(synth_step_o), 32'h1);
    wait_rdy(1'b0);
    rd(8'h04, 32'h0000_80F0);
    rd(8'h00, 32'h0000_7FFF);
    chk("pwr off", 32'(adc_pwr_o), 32'h0);
    rd(8'h54, 32'h0000_0002);
    $display("test single full scale done");
    conclude();
  end
endmodule
